// *** core/acmd_core.sv ***
// Functional notes
// [R1] reset starts default measurement, front end feeding
// [R2] mode 010 selects optional measurement mode
// [R3] wideband option bypasses low-pass filter
// [R4] narrowband option filters harder, halves rate
// [R5] six axis bytes readable singly or burst
// [R6] overflow shows 011 or 100 top bits
// [R7] sign plus twelve bits, low three zero
// [R8] saturated pattern until valid value read
// [R9] host discards overflow samples
// [R10] valid codes span -3072 to 3071
// [R11] motion mode routes samples to band-pass
// [R12] band-pass corners near 0.05-1 and 25-60 Hz
// [R13] threshold between zero and full scale
// [R14] allowed axis over threshold fires (OR)
// [R15] all required axes exceeded fires (AND)
// [R16] mode 011 enters motion detection
// [R17] require, allow bits plus per-axis thresholds
// [R18] no acceleration data in motion mode
// [R19] unlock 00h 50h A0h before indirect writes
// [R20] select index 02h, data goes to control
// [R21] bit0 allows X, bit1 allows Y
// [R22] motion condition asserts interrupt pin
// [R23] status read acknowledges, shows axis bits
// [R24] polarity bit selects pin active level
// [R25] absolute filtered value compared per axis
`timescale 1ns/1ps
`default_nettype none
module acmd_core #(
    parameter bit NARROW_VARIANT = 1'b0
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire acmd_pkg::acmd_sample_t samp,
    input wire acmd_pkg::acmd_bus_t bus,
    output logic [7:0] rdata,
    output logic irq_pin
);
    import acmd_pkg::*;

    logic [1:0] rst_pipe;
    wire rst_n = rst_pipe[1];

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    // register port decode
    wire wr_mode = bus.wr && bus.addr == ADDR_MODE;
    wire wr_unlock = bus.wr && bus.addr == ADDR_UNLOCK;
    wire wr_sel = bus.wr && bus.addr == ADDR_CTRL_SEL;
    wire wr_data = bus.wr && bus.addr == ADDR_CTRL_DATA;
    wire wr_mask = bus.wr && bus.addr == ADDR_INT_MASK;
    wire rd_status = bus.rd && bus.addr == ADDR_INT_STATUS;

    logic [7:0] mode_reg;
    logic [7:0] int_mask;
    logic [7:0] ctrl_sel;
    logic [7:0] motion_control_reg;
    logic [7:0] thr_reg [3];

    wire [2:0] mode_field = mode_reg[MODE_LSB +: MODE_W];
    wire in_motion = mode_field == MODE_MOTION; // [R16]
    wire in_option = mode_field == MODE_OPTIONAL; // [R2]
    wire opt_bypass = in_option && !NARROW_VARIANT; // [R3]
    wire opt_narrow = in_option && NARROW_VARIANT; // [R4]

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= RST_MODE; // [R1]
            int_mask <= RST_INT_MASK;
            ctrl_sel <= 8'h00;
        end else begin
            if (wr_mode) begin
                mode_reg <= bus.wdata;
            end
            if (wr_mask) begin
                int_mask <= bus.wdata;
            end
            if (wr_sel) begin
                ctrl_sel <= bus.wdata;
            end
        end
    end

    // unlock sequence
    acmd_unlock_t ul_state;
    acmd_unlock_t next_ul_state;

    always_comb begin
        next_ul_state = ul_state;
        if (wr_unlock) begin
            unique case (ul_state)
                UL_ZERO: begin
                    next_ul_state = bus.wdata == UNLOCK_B1 ? UL_HALF
                        : bus.wdata == UNLOCK_B0 ? UL_ZERO : UL_IDLE;
                end
                UL_HALF: begin
                    next_ul_state = bus.wdata == UNLOCK_B2 ? UL_OPEN
                        : bus.wdata == UNLOCK_B0 ? UL_ZERO : UL_IDLE;
                end
                default: begin
                    next_ul_state = bus.wdata == UNLOCK_B0 ? UL_ZERO
                        : UL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ul_state <= UL_IDLE;
        end else begin
            ul_state <= next_ul_state; // [R19]
        end
    end

    // indirect writes only land once the sequence completed
    wire ind_wr = wr_data && ul_state == UL_OPEN; // [R19]
    wire ind_mc = ind_wr && ctrl_sel == IDX_MOTION_CTRL; // [R20]

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            motion_control_reg <= RST_MOTION_CTRL;
            thr_reg[0] <= RST_THR;
            thr_reg[1] <= RST_THR;
            thr_reg[2] <= RST_THR;
        end else begin
            if (ind_mc) begin
                motion_control_reg <= bus.wdata; // [R20] [R17]
            end
            if (ind_wr && ctrl_sel == IDX_X_THR) begin
                thr_reg[0] <= bus.wdata; // [R17]
            end
            if (ind_wr && ctrl_sel == IDX_Y_THR) begin
                thr_reg[1] <= bus.wdata;
            end
            if (ind_wr && ctrl_sel == IDX_Z_THR) begin
                thr_reg[2] <= bus.wdata;
            end
        end
    end

    wire [7:0] ind_rd_val =
        ctrl_sel == IDX_MOTION_CTRL ? motion_control_reg
        : ctrl_sel == IDX_X_THR ? thr_reg[0]
        : ctrl_sel == IDX_Y_THR ? thr_reg[1]
        : ctrl_sel == IDX_Z_THR ? thr_reg[2] : 8'h00;

    // narrowband decimation
    logic decim_phase;
    wire take_sample = samp.valid && !in_motion
        && (!opt_narrow || decim_phase); // [R4] [R18]

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            decim_phase <= 1'b0;
        end else if (samp.valid) begin
            decim_phase <= !decim_phase;
        end
    end

    // per-axis channels
    logic signed [SAMP_W-1:0] in_axis [3];
    assign in_axis[0] = samp.x;
    assign in_axis[1] = samp.y;
    assign in_axis[2] = samp.z;

    logic [CODE_W-1:0] code [3];
    logic [2:0] exceed;
    logic [2:0] msb_read;
    assign msb_read[0] = bus.rd && bus.addr == ADDR_X_MSB;
    assign msb_read[1] = bus.rd && bus.addr == ADDR_Y_MSB;
    assign msb_read[2] = bus.rd && bus.addr == ADDR_Z_MSB;

    genvar ax;
    generate
        for (ax = 0; ax < 3; ax++) begin : g_axis
            logic signed [FILT_W-1:0] lp;
            logic signed [FILT_W-1:0] hp_avg;
            logic signed [FILT_W-1:0] bp;
            logic hold;
            logic hold_neg;
            wire signed [FILT_W-1:0] xin = FILT_W'(in_axis[ax]);
            // signal channel low-pass; shift picks the bandwidth
            wire signed [FILT_W-1:0] lp_diff = xin - lp;
            wire signed [FILT_W-1:0] next_lp = lp + (opt_narrow
                ? (lp_diff >>> LP_SHIFT_NARROW)
                : (lp_diff >>> LP_SHIFT_NORM)); // [R4]
            wire signed [FILT_W-1:0] chan = opt_bypass ? xin : lp; // [R3]
            // no limiter: out-of-range samples are marked, not clamped
            wire over_pos = chan > CODE_MAX; // [R10]
            wire over_neg = chan < CODE_MIN; // [R10]
            wire [CODE_W-1:0] next_code = over_pos ? OVF_POS_CODE // [R6]
                : over_neg ? OVF_NEG_CODE
                : hold ? (hold_neg ? SAT_NEG_CODE : SAT_POS_CODE) // [R8]
                : chan[CODE_W-1:0]; // [R7]
            // band-pass: slow average removed, then light smoothing
            wire signed [FILT_W-1:0] hp = xin - hp_avg; // [R12]
            wire signed [FILT_W-1:0] next_bp = bp
                + ((hp - bp) >>> BP_SHIFT); // [R12]
            wire [FILT_W-1:0] bp_abs = bp[FILT_W-1]
                ? FILT_W'(-bp) : FILT_W'(bp); // [R25]
            wire [15:0] thr_eff = (thr_reg[ax] == 8'h00
                ? 16'h0001 : {8'h00, thr_reg[ax]}) * THR_STEP; // [R13]

            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    lp <= '0;
                    hp_avg <= '0;
                    bp <= '0;
                end else if (samp.valid) begin
                    lp <= next_lp; // [R1]
                    if (in_motion) begin
                        hp_avg <= hp_avg + (hp >>> HP_SHIFT); // [R11]
                        bp <= next_bp;
                    end
                end
            end

            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    code[ax] <= '0;
                    hold <= 1'b0;
                    hold_neg <= 1'b0;
                end else begin
                    if (take_sample) begin
                        code[ax] <= next_code; // [R5]
                    end
                    // a fresh overflow beats the clearing read
                    if (take_sample && (over_pos || over_neg)) begin
                        hold <= 1'b1; // [R8]
                        hold_neg <= over_neg;
                    end else if (msb_read[ax]) begin
                        hold <= 1'b0; // [R8]
                    end
                end
            end

            assign exceed[ax] = in_motion && samp.valid
                && {1'b0, bp_abs} > {2'b00, thr_eff}; // [R25] [R11]
        end
    endgenerate

    // trigger logic and status
    logic [2:0] axis_flag;
    logic motion_flag;
    wire [2:0] allow = motion_control_reg[MC_ALLOW_LSB +: 3]; // [R21]
    wire [2:0] require_ax = motion_control_reg[MC_REQ_LSB +: 3];
    wire [2:0] seen = axis_flag | exceed;
    wire or_hit = |(allow & exceed); // [R14]
    wire and_hit = |require_ax && &(seen | ~require_ax)
        && |exceed; // [R15]
    wire motion_hit = in_motion && (or_hit || and_hit);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            axis_flag <= 3'b000;
            motion_flag <= 1'b0;
        end else begin
            // set wins over the acknowledging read
            axis_flag <= (rd_status ? 3'b000 : axis_flag)
                | exceed; // [R23]
            motion_flag <= (motion_flag && !rd_status)
                || motion_hit; // [R23]
        end
    end

    wire [7:0] status_val = {4'h0, motion_flag, axis_flag};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pin <= 1'b1;
        end else begin
            irq_pin <= motion_flag == int_mask[IM_POL_BIT]; // [R22] [R24]
        end
    end

    // read data
    // motion mode hides acceleration bytes
    wire show = !in_motion; // [R18]
    wire [7:0] msb_of [3];
    wire [7:0] lsb_of [3];
    assign msb_of[0] = show ? code[0][12:5] : 8'h00;
    assign msb_of[1] = show ? code[1][12:5] : 8'h00;
    assign msb_of[2] = show ? code[2][12:5] : 8'h00;
    assign lsb_of[0] = show ? {code[0][4:0], {LOW_PAD_W{1'b0}}} : 8'h00;
    assign lsb_of[1] = show ? {code[1][4:0], {LOW_PAD_W{1'b0}}} : 8'h00;
    assign lsb_of[2] = show ? {code[2][4:0], {LOW_PAD_W{1'b0}}} : 8'h00;

    wire [7:0] next_rdata = !bus.rd ? 8'h00
        : bus.addr == ADDR_X_LSB ? lsb_of[0] // [R5] [R7]
        : bus.addr == ADDR_X_MSB ? msb_of[0]
        : bus.addr == ADDR_Y_LSB ? lsb_of[1]
        : bus.addr == ADDR_Y_MSB ? msb_of[1]
        : bus.addr == ADDR_Z_LSB ? lsb_of[2]
        : bus.addr == ADDR_Z_MSB ? msb_of[2]
        : bus.addr == ADDR_MODE ? mode_reg
        : bus.addr == ADDR_INT_STATUS ? status_val // [R23]
        : bus.addr == ADDR_INT_MASK ? int_mask
        : bus.addr == ADDR_CTRL_SEL ? ctrl_sel
        : bus.addr == ADDR_CTRL_DATA ? ind_rd_val : 8'h00;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// *** core/acmd_pkg.sv ***
package acmd_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_X_LSB = 8'h04;
    localparam logic [7:0] ADDR_X_MSB = 8'h05;
    localparam logic [7:0] ADDR_Y_LSB = 8'h06;
    localparam logic [7:0] ADDR_Y_MSB = 8'h07;
    localparam logic [7:0] ADDR_Z_LSB = 8'h08;
    localparam logic [7:0] ADDR_Z_MSB = 8'h09;
    localparam logic [7:0] ADDR_MODE = 8'h14;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h16;
    localparam logic [7:0] ADDR_CTRL_SEL = 8'h18;
    localparam logic [7:0] ADDR_UNLOCK = 8'h1e;
    localparam logic [7:0] ADDR_INT_MASK = 8'h21;
    localparam logic [7:0] ADDR_CTRL_DATA = 8'h22;
    // indirect register indices
    localparam logic [7:0] IDX_MOTION_CTRL = 8'h02;
    localparam logic [7:0] IDX_X_THR = 8'h03;
    localparam logic [7:0] IDX_Y_THR = 8'h04;
    localparam logic [7:0] IDX_Z_THR = 8'h05;
    // mode field
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;
    localparam logic [2:0] MODE_MEASURE = 3'h0;
    localparam logic [2:0] MODE_OPTIONAL = 3'h2;
    localparam logic [2:0] MODE_MOTION = 3'h3;
    // unlock sequence bytes
    localparam logic [7:0] UNLOCK_B0 = 8'h00;
    localparam logic [7:0] UNLOCK_B1 = 8'h50;
    localparam logic [7:0] UNLOCK_B2 = 8'ha0;
    // motion control fields: allow [2:0], require [5:3]
    localparam int MC_ALLOW_LSB = 0;
    localparam int MC_REQ_LSB = 3;
    // interrupt mask / status fields
    localparam int IM_POL_BIT = 0;
    localparam int IS_AXIS_LSB = 0;
    localparam int IS_MOTION_BIT = 3;
    // reset values
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_INT_MASK = 8'h00;
    localparam logic [7:0] RST_MOTION_CTRL = 8'h00;
    localparam logic [7:0] RST_THR = 8'h80;
    // sample and output code
    localparam int SAMP_W = 15;
    localparam int CODE_W = 13;
    localparam int FILT_W = 17;
    localparam logic signed [FILT_W-1:0] CODE_MAX = 17'sd3071;
    localparam logic signed [FILT_W-1:0] CODE_MIN = -17'sd3072;
    localparam logic [CODE_W-1:0] OVF_POS_CODE = 13'h0c00;
    localparam logic [CODE_W-1:0] OVF_NEG_CODE = 13'h13ff;
    localparam logic [CODE_W-1:0] SAT_POS_CODE = 13'h0bff;
    localparam logic [CODE_W-1:0] SAT_NEG_CODE = 13'h1400;
    localparam int LOW_PAD_W = 3;
    // filter shifts
    localparam int LP_SHIFT_NORM = 2;
    localparam int LP_SHIFT_NARROW = 4;
    localparam int HP_SHIFT = 8;
    localparam int BP_SHIFT = 1;
    // threshold scale: 255 steps stay under full scale
    localparam logic [15:0] THR_STEP = 16'h000c;

    typedef struct packed {
        logic valid;
        logic signed [SAMP_W-1:0] x;
        logic signed [SAMP_W-1:0] y;
        logic signed [SAMP_W-1:0] z;
    } acmd_sample_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } acmd_bus_t;

    typedef enum logic [3:0] {
        UL_IDLE = 4'b0001,
        UL_ZERO = 4'b0010,
        UL_HALF = 4'b0100,
        UL_OPEN = 4'b1000
    } acmd_unlock_t;
endpackage

// *** verification/accel_mode_and_motion_detect_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define chk(a, b) begin total_checks++; if ((a) !== (b)) begin \
    miscompares++; $display("Error %0t: got %h want %h", $time, a, b); \
    end end
module accel_mode_and_motion_detect_bench;
    import acmd_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    acmd_sample_t samp = '0;
    acmd_bus_t bus;
    logic [7:0] rdata;
    logic irq_pin;
    logic [7:0] d;
    int miscompares = 0;
    int total_checks = 0;

    always #2 mclk = ~mclk;

    acmd_core #(.NARROW_VARIANT(1'b0)) acmd_core_inst (
        .mclk(mclk),
        .reset_n(reset_n),
        .samp(samp),
        .bus(bus),
        .rdata(rdata),
        .irq_pin(irq_pin)
    );
    acmd_host_model acmd_host_model_inst (
        .mclk(mclk),
        .rdata(rdata),
        .bus(bus)
    );

    task automatic close_out();
        if (miscompares == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        acmd_host_model_inst.wr(a, v);
    endtask

    task automatic br(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        acmd_host_model_inst.rd(a, v);
        `chk(v, e)
    endtask

    // burst order: high byte first, then the one below it
    task automatic axis(input logic [7:0] msb, input logic [12:0] c);
        br(msb, c[12:5]);
        br(msb - 8'h01, {c[4:0], 3'h0});
    endtask

    task automatic send(input logic signed [14:0] x, y, z);
        @(posedge mclk);
        samp <= '{1'b1, x, y, z};
        @(posedge mclk);
        samp.valid <= 1'b0;
    endtask

    task automatic feed(input logic signed [14:0] x, y, z);
        repeat (10) send(x, y, z);
        repeat (3) @(posedge mclk);
        #1;
    endtask

    task automatic t_default();
        br(ADDR_MODE, 8'h00);
        repeat (2) send(15'sd400, 15'sd0, 15'sd0);
        axis(ADDR_X_MSB, 13'h0064);
    endtask

    task automatic t_bypass();
        wr(ADDR_MODE, 8'h02);
        br(ADDR_MODE, 8'h02);
        repeat (2) send(15'sd400, -15'sd400, 15'sd7);
        axis(ADDR_Z_MSB, 13'h0007);
        axis(ADDR_Y_MSB, 13'h1e70);
        axis(ADDR_X_MSB, 13'h0190);
    endtask

    task automatic t_overflow();
        repeat (2) send(15'sd3072, -15'sd3073, 15'sd0);
        repeat (2) send(15'sd100, -15'sd5, 15'sd0);
        axis(ADDR_X_MSB, SAT_POS_CODE);
        axis(ADDR_Y_MSB, SAT_NEG_CODE);
        repeat (2) send(15'sd100, -15'sd5, 15'sd0);
        axis(ADDR_X_MSB, 13'h0064);
        axis(ADDR_Y_MSB, 13'h1ffb);
        repeat (2) send(15'sd3072, -15'sd3073, 15'sd0);
        acmd_host_model_inst.rd(ADDR_X_MSB, d);
        `chk(acmd_host_model_inst.ovf(d), 1'b1)
        `chk(d, OVF_POS_CODE[12:5])
        br(ADDR_Y_MSB, OVF_NEG_CODE[12:5]);
        repeat (2) send(15'sd3071, -15'sd3072, 15'sd0);
        axis(ADDR_X_MSB, 13'h0bff);
        axis(ADDR_Y_MSB, 13'h1400);
    endtask

    task automatic t_motion();
        wr(ADDR_MODE, 8'h03);
        br(ADDR_MODE, 8'h03);
        br(ADDR_X_MSB, 8'h00);
        br(8'h3f, 8'h00);
        acmd_host_model_inst.ind_wr(IDX_MOTION_CTRL, 8'h07);
        br(ADDR_CTRL_DATA, RST_MOTION_CTRL);
        wr(ADDR_UNLOCK, UNLOCK_B0);
        wr(ADDR_UNLOCK, UNLOCK_B2);
        acmd_host_model_inst.ind_wr(IDX_MOTION_CTRL, 8'h07);
        br(ADDR_CTRL_DATA, RST_MOTION_CTRL);
        acmd_host_model_inst.unlock();
        // lowest step keeps the comparator well inside a big step
        acmd_host_model_inst.ind_wr(IDX_X_THR, 8'h01);
        acmd_host_model_inst.ind_wr(IDX_Y_THR, 8'h01);
        acmd_host_model_inst.ind_wr(IDX_Z_THR, 8'h01);
        acmd_host_model_inst.ind_wr(IDX_MOTION_CTRL, 8'h03);
        br(ADDR_CTRL_DATA, 8'h03);
        feed(15'sd0, 15'sd0, 15'sd16000);
        `chk(irq_pin, 1'b1)
        br(ADDR_INT_STATUS, 8'h04);
        feed(15'sd16000, 15'sd0, 15'sd0);
        `chk(irq_pin, 1'b0)
        acmd_host_model_inst.rd(ADDR_INT_STATUS, d);
        `chk(d[IS_MOTION_BIT], 1'b1)
        `chk(d[IS_AXIS_LSB], 1'b1)
        repeat (2) @(posedge mclk);
        #1;
        `chk(irq_pin, 1'b1)
        wr(ADDR_INT_MASK, 8'h01);
        repeat (3) @(posedge mclk);
        #1;
        `chk(irq_pin, 1'b0)
        acmd_host_model_inst.ind_wr(IDX_MOTION_CTRL, 8'h18);
        acmd_host_model_inst.rd(ADDR_INT_STATUS, d);
        feed(-15'sd16000, 15'sd0, 15'sd0);
        `chk(irq_pin, 1'b0)
        feed(-15'sd16000, 15'sd16000, 15'sd0);
        `chk(irq_pin, 1'b1)
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_default();
        t_bypass();
        t_overflow();
        t_motion();
        close_out();
    end

    // whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        close_out();
    end
endmodule
`default_nettype wire

// *** verification/acmd_core_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module acmd_core_monitor #(
    parameter bit NARROW_VARIANT = 1'b0
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire acmd_pkg::acmd_sample_t samp,
    input wire acmd_pkg::acmd_bus_t bus,
    input wire logic [7:0] rdata,
    input wire logic irq_pin
);
    import acmd_pkg::*;
    logic pol_q;
    logic [2:0] mode_q;
    wire logic wr_pol = bus.wr && bus.addr == ADDR_INT_MASK;
    wire logic wr_mode = bus.wr && bus.addr == ADDR_MODE;
    wire logic rd_stat = bus.rd && bus.addr == ADDR_INT_STATUS;
    wire logic is_axis = bus.addr >= ADDR_X_LSB && bus.addr <= ADDR_Z_MSB;
    wire logic mapped = is_axis || bus.addr == ADDR_MODE ||
        bus.addr == ADDR_INT_STATUS || bus.addr == ADDR_CTRL_SEL ||
        bus.addr == ADDR_UNLOCK || bus.addr == ADDR_INT_MASK ||
        bus.addr == ADDR_CTRL_DATA;
    wire logic rd_unmapped = bus.rd && !mapped;
    wire logic rd_lsb = bus.rd && is_axis && !bus.addr[0];
    wire logic rd_hidden = bus.rd && is_axis && mode_q == MODE_MOTION;
    // pin level alone is ambiguous; pair it with the tracked polarity
    wire logic irq_on = irq_pin == pol_q;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pol_q <= 1'b0;
            mode_q <= MODE_MEASURE;
        end else begin
            if (wr_pol) pol_q <= bus.wdata[IM_POL_BIT];
            if (wr_mode) mode_q <= bus.wdata[2:0];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_mode_set;
        wr_mode;
    endsequence
    sequence s_mode_get;
        bus.rd && bus.addr == ADDR_MODE;
    endsequence
    sequence s_ack;
        rd_stat && !samp.valid ##1 !samp.valid && !wr_pol;
    endsequence
    sequence s_quiet;
        (!samp.valid && !rd_stat && !wr_pol) [*2];
    endsequence

    a_idle_read_zero: assert property (
        !$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data outside read slot");
    a_unmapped_read: assert property (
        $past(rd_unmapped) |-> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_lsb_pad_zero: assert property (
        $past(rd_lsb) |-> rdata[2:0] == 3'h0)
        else $error("low byte pad bits not zero");
    a_motion_hides_data: assert property (
        $past(rd_hidden) |-> rdata == 8'h00)
        else $error("axis data visible in motion mode");
    a_mode_readback: assert property (
        s_mode_set ##2 s_mode_get |-> ##1
        rdata[2:0] == $past(bus.wdata[2:0], 3))
        else $error("mode field readback wrong");
    a_irq_after_sample: assert property (
        $rose(irq_on) && !$past(wr_pol) && !$past(wr_pol, 2) |->
        $past(samp.valid, 2))
        else $error("interrupt without sample cause");
    a_irq_quiet_hold: assert property (
        s_quiet |-> ##1 $stable(irq_pin))
        else $error("interrupt pin moved without cause");
    a_irq_ack_clear: assert property (
        s_ack |-> ##1 !irq_on)
        else $error("status read did not clear interrupt");
    a_status_axis_set: assert property (
        $past(rd_stat) && rdata[IS_MOTION_BIT] |-> rdata[2:0] != 3'h0)
        else $error("motion event without axis flag");
endmodule

bind acmd_core acmd_core_monitor #(
    .NARROW_VARIANT(NARROW_VARIANT)
) acmd_core_monitor_inst (
    .mclk(mclk),
    .reset_n(reset_n),
    .samp(samp),
    .bus(bus),
    .rdata(rdata),
    .irq_pin(irq_pin)
);
`default_nettype wire

// *** verification/acmd_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module acmd_host_model (
    input wire logic mclk,
    input wire logic [7:0] rdata,
    output var acmd_pkg::acmd_bus_t bus
);
    import acmd_pkg::*;
    initial bus = '0;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic unlock();
        wr(ADDR_UNLOCK, UNLOCK_B0);
        wr(ADDR_UNLOCK, UNLOCK_B1);
        wr(ADDR_UNLOCK, UNLOCK_B2);
    endtask

    task automatic ind_wr(input logic [7:0] idx, input logic [7:0] d);
        wr(ADDR_CTRL_SEL, idx);
        wr(ADDR_CTRL_DATA, d);
    endtask

    // samples showing this pattern get thrown away
    function automatic logic ovf(input logic [7:0] msb);
        return msb[7:5] == 3'b011 || msb[7:5] == 3'b100;
    endfunction
endmodule
`default_nettype wire
